// file: gdc_pkg.sv
// Package with the register map, field layout and current tables of the gate-drive config bank.
package gdc_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam int          STRB_W      = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam int          NUM_HB      = 3;
   localparam logic [5:0]  IDX_HB1     = 6'h0F;
   localparam logic [5:0]  IDX_HB2     = 6'h10;
   localparam logic [5:0]  IDX_HB3     = 6'h11;
   localparam logic [5:0]  IDX_LOW     = 6'h17;

   // ---------------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  CFG_RESET   = 8'hFF;
   localparam logic [7:0]  LOW_RESET   = 8'h00;
   localparam int          SRC_MSB     = 7;
   localparam int          SRC_LSB     = 4;
   localparam int          SNK_MSB     = 3;
   localparam int          SNK_LSB     = 0;
   localparam int          LOW_HB1_BIT = 7;
   localparam logic [7:0]  LOW_MASK    = 8'hE0;

   // ---------------------------------------------------------------
   // Peak currents in microamps, indexed by the 4-bit code
   // ---------------------------------------------------------------
   localparam logic [15:0] STD_UA [16] = '{
      16'h01F4, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0FA0, 16'h1388, 16'h1770, 16'h1B58,
      16'h1F40, 16'h2EE0, 16'h3E80, 16'h4E20, 16'h5DC0, 16'h7918, 16'hBB80, 16'hF230};
   localparam logic [15:0] LOW_UA [16] = '{
      16'h0032, 16'h006E, 16'h00AA, 16'h00E6, 16'h0122, 16'h015E, 16'h019A, 16'h0258,
      16'h02D5, 16'h0352, 16'h03E8, 16'h04B0, 16'h0578, 16'h0640, 16'h0708, 16'h08FC};

   typedef struct packed {
      logic [3:0]  source_code;
      logic [3:0]  sink_code;
      logic        low_current_enable;
      logic [15:0] source_ua;
      logic [15:0] sink_ua;
   } hb_drive_s;

endpackage

// file: gate_drive_current_cfg_regs.sv
// AXI4-Lite register bank for the half-bridge 1-3 gate-drive source/sink current settings.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns

module gate_drive_current_cfg_regs (
   input  wire logic                      CLK,
   input  wire logic                      ARST_N,
   input  wire logic                      CE,
   input  wire logic [gdc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                      S_AXI_AWVALID,
   output      logic                      S_AXI_AWREADY,
   input  wire logic [gdc_pkg::DATA_W-1:0] S_AXI_WDATA,
   input  wire logic [gdc_pkg::STRB_W-1:0] S_AXI_WSTRB,
   input  wire logic                      S_AXI_WVALID,
   output      logic                      S_AXI_WREADY,
   output      logic [1:0]                S_AXI_BRESP,
   output      logic                      S_AXI_BVALID,
   input  wire logic                      S_AXI_BREADY,
   input  wire logic [gdc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                      S_AXI_ARVALID,
   output      logic                      S_AXI_ARREADY,
   output      logic [gdc_pkg::DATA_W-1:0] S_AXI_RDATA,
   output      logic [1:0]                S_AXI_RRESP,
   output      logic                      S_AXI_RVALID,
   input  wire logic                      S_AXI_RREADY,
   output      gdc_pkg::hb_drive_s [gdc_pkg::NUM_HB-1:0] HB_DRIVE
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0]                aw_idx_reg;
   logic [7:0]                aw_idx_next;
   logic                      aw_hold_reg;
   logic                      aw_hold_next;
   logic [7:0]                w_data_reg;
   logic [7:0]                w_data_next;
   logic                      w_strb_reg;
   logic                      w_strb_next;
   logic                      w_hold_reg;
   logic                      w_hold_next;
   logic                      bvalid_reg;
   logic                      bvalid_next;
   logic [1:0]                bresp_reg;
   logic [1:0]                bresp_next;
   logic                      rvalid_reg;
   logic                      rvalid_next;
   logic [1:0]                rresp_reg;
   logic [1:0]                rresp_next;
   logic [gdc_pkg::DATA_W-1:0] rdata_reg;
   logic [gdc_pkg::DATA_W-1:0] rdata_next;
   logic [7:0]                cfg_reg  [gdc_pkg::NUM_HB];
   logic [7:0]                cfg_next [gdc_pkg::NUM_HB];
   logic [7:0]                low_reg;
   logic [7:0]                low_next;
   gdc_pkg::hb_drive_s [gdc_pkg::NUM_HB-1:0] drive_reg;
   gdc_pkg::hb_drive_s [gdc_pkg::NUM_HB-1:0] drive_next;

   logic                      aw_take;
   logic                      w_take;
   logic                      ar_take;
   logic                      wr_fire;
   logic [5:0]                ar_idx;
   logic [7:0]                rd_byte;
   logic                      rd_hit;
   logic                      wr_hit;

   // ---------------------------------------------------------------
   // Handshakes
   // ---------------------------------------------------------------
   // Readies drop while CE is low so that no beat is taken by frozen logic.
   // Limitation: a response that is up while CE is low cannot be retired, so a master must
   // keep its ready asserted until CE returns.
   assign S_AXI_AWREADY = CE && !aw_hold_reg && !bvalid_reg;
   assign S_AXI_WREADY  = CE && !w_hold_reg && !bvalid_reg;
   assign S_AXI_ARREADY = CE && !rvalid_reg;
   assign aw_take       = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_take        = S_AXI_WVALID && S_AXI_WREADY;
   assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;
   // Address and data may arrive in either order; each half is parked until its partner comes.
   // The write lands once both halves are held, one edge after the later one arrives, and
   // the response rises on that same edge. Both readies stay low until the response is
   // retired, which keeps a second write from overtaking the first.
   assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign ar_idx        = S_AXI_ARADDR[7:2];

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Every data output is a flop; only the readies above are combinational.
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RRESP   = rresp_reg;
   assign S_AXI_RDATA   = rdata_reg;
   assign HB_DRIVE      = drive_reg;

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   always_comb begin
      aw_idx_next  = aw_idx_reg;
      aw_hold_next = aw_hold_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      w_hold_next  = w_hold_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (aw_take) begin
         // Only six index bits exist; the top two stay zero.
         aw_idx_next  = {2'h0, S_AXI_AWADDR[7:2]};
         aw_hold_next = 1'b1;
      end
      if (w_take) begin
         w_data_next = S_AXI_WDATA[7:0];
         w_strb_next = S_AXI_WSTRB[0];
         w_hold_next = 1'b1;
      end
      if (wr_fire) begin
         aw_hold_next = 1'b0;
         w_hold_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? gdc_pkg::RESP_OKAY : gdc_pkg::RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_idx_reg  <= 8'h00;
         aw_hold_reg <= 1'b0;
         w_data_reg  <= 8'h00;
         w_strb_reg  <= 1'b0;
         w_hold_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= gdc_pkg::RESP_OKAY;
      end else if (CE) begin
         aw_idx_reg  <= aw_idx_next;
         aw_hold_reg <= aw_hold_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         w_hold_reg  <= w_hold_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Only byte lane 0 carries data; a write with that lane off changes nothing.
   // Such a write still answers OKAY, since the register exists and merely kept its value.
   // The low-current enables sit at bits 7:5, one per half-bridge; the lower bits are not
   // stored and read as zero.
   always_comb begin
      wr_hit   = 1'b0;
      low_next = low_reg;
      for (int i = 0; i < gdc_pkg::NUM_HB; i++) begin
         cfg_next[i] = cfg_reg[i];
      end
      if (wr_fire) begin
         case (aw_idx_reg[5:0])
            gdc_pkg::IDX_HB1: begin
               wr_hit = 1'b1;
               if (w_strb_reg) cfg_next[0] = w_data_reg;
            end
            gdc_pkg::IDX_HB2: begin
               wr_hit = 1'b1;
               if (w_strb_reg) cfg_next[1] = w_data_reg;
            end
            gdc_pkg::IDX_HB3: begin
               wr_hit = 1'b1;
               if (w_strb_reg) cfg_next[2] = w_data_reg;
            end
            gdc_pkg::IDX_LOW: begin
               wr_hit = 1'b1;
               if (w_strb_reg) low_next = w_data_reg & gdc_pkg::LOW_MASK;
            end
            default: begin
               // Unmapped indices answer SLVERR so that a stray access is visible.
               wr_hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < gdc_pkg::NUM_HB; i++) begin
            cfg_reg[i] <= gdc_pkg::CFG_RESET;
         end
         low_reg <= gdc_pkg::LOW_RESET;
      end else if (CE) begin
         for (int i = 0; i < gdc_pkg::NUM_HB; i++) begin
            cfg_reg[i] <= cfg_next[i];
         end
         low_reg <= low_next;
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   // A read answers on the same edge that takes its address. ARREADY stays low while an
   // answer waits, so at most one read is open; the upper three data bytes read as zero.
   // A read and a write may overlap; they share no state but the registers.
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (ar_idx)
         gdc_pkg::IDX_HB1: rd_byte = cfg_reg[0];
         gdc_pkg::IDX_HB2: rd_byte = cfg_reg[1];
         gdc_pkg::IDX_HB3: rd_byte = cfg_reg[2];
         gdc_pkg::IDX_LOW: rd_byte = low_reg;
         default: begin
            rd_hit  = 1'b0;
            rd_byte = 8'h00;
         end
      endcase
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      if (ar_take) begin
         rvalid_next = 1'b1;
         rdata_next  = {24'h000000, rd_byte};
         rresp_next  = rd_hit ? gdc_pkg::RESP_OKAY : gdc_pkg::RESP_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= gdc_pkg::RESP_OKAY;
         rdata_reg  <= 32'h00000000;
      end else if (CE) begin
         rvalid_reg <= rvalid_next;
         rresp_reg  <= rresp_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // Driver current decode
   // ---------------------------------------------------------------
   // The decode is registered so the analog side sees glitch-free codes; it trails the
   // register contents by one clock and needs no trigger.
   // A write therefore shows on HB_DRIVE two edges after the later of address and data.
   for (genvar g = 0; g < gdc_pkg::NUM_HB; g++) begin : g_hb
      logic [3:0] src;
      logic [3:0] snk;
      logic       low;
      assign src = cfg_reg[g][gdc_pkg::SRC_MSB:gdc_pkg::SRC_LSB];
      assign snk = cfg_reg[g][gdc_pkg::SNK_MSB:gdc_pkg::SNK_LSB];
      // Half-bridge 1 owns the top enable bit, so bridge g reads the bit g places below it.
      assign low = low_reg[gdc_pkg::LOW_HB1_BIT-g];
      always_comb begin
         drive_next[g].source_code        = src;
         drive_next[g].sink_code          = snk;
         drive_next[g].low_current_enable = low;
         if (low) begin
            drive_next[g].source_ua = gdc_pkg::LOW_UA[src];
            drive_next[g].sink_ua   = gdc_pkg::LOW_UA[snk];
         end else begin
            drive_next[g].source_ua = gdc_pkg::STD_UA[src];
            drive_next[g].sink_ua   = gdc_pkg::STD_UA[snk];
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         // Reset loads the standard-table decode of the all-ones codes the registers hold.
         for (int i = 0; i < gdc_pkg::NUM_HB; i++) begin
            drive_reg[i].source_code        <=
               gdc_pkg::CFG_RESET[gdc_pkg::SRC_MSB:gdc_pkg::SRC_LSB];
            drive_reg[i].sink_code          <=
               gdc_pkg::CFG_RESET[gdc_pkg::SNK_MSB:gdc_pkg::SNK_LSB];
            drive_reg[i].low_current_enable <= 1'b0;
            drive_reg[i].source_ua          <= gdc_pkg::STD_UA[15];
            drive_reg[i].sink_ua            <= gdc_pkg::STD_UA[15];
         end
      end else if (CE) begin
         drive_reg <= drive_next;
      end
   end

endmodule

// file: gate_drive_current_cfg_regs_asserts.sv
// Concurrent checks on the ports of the gate-drive current register bank.
`timescale 1ns/1ns
module gate_drive_current_cfg_regs_asserts (
   input wire logic                    CLK,
   input wire logic                    ARST_N,
   input wire logic                    CE,
   input wire logic [7:0]              S_AXI_AWADDR,
   input wire logic                    S_AXI_AWVALID,
   input wire logic                    S_AXI_AWREADY,
   input wire logic [31:0]             S_AXI_WDATA,
   input wire logic [3:0]              S_AXI_WSTRB,
   input wire logic                    S_AXI_WVALID,
   input wire logic                    S_AXI_WREADY,
   input wire logic [1:0]              S_AXI_BRESP,
   input wire logic                    S_AXI_BVALID,
   input wire logic                    S_AXI_ARVALID,
   input wire logic                    S_AXI_ARREADY,
   input wire logic [31:0]             S_AXI_RDATA,
   input wire logic                    S_AXI_RVALID,
   input wire gdc_pkg::hb_drive_s [2:0] HB_DRIVE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // The write checks only cover address and data taken on the same edge.
   sequence s_wr_hb1;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_WSTRB[0]
         && S_AXI_AWADDR[7:2] == gdc_pkg::IDX_HB1;
   endsequence
   // The register lands one edge after the take and the decode one edge later, so the new
   // codes are first sampled on the third edge after the take.
   property p_wr_hb1;
      s_wr_hb1 |-> ##3 {HB_DRIVE[0].source_code, HB_DRIVE[0].sink_code}
         == $past(S_AXI_WDATA[7:0], 3);
   endproperty
   property p_wr_resp;
      s_wr_hb1 |-> ##2 S_AXI_BVALID && S_AXI_BRESP == gdc_pkg::RESP_OKAY;
   endproperty
   property p_reset_val;
      $rose(ARST_N) |-> HB_DRIVE[0].source_code == 4'hF && HB_DRIVE[1].sink_code == 4'hF
         && HB_DRIVE[2].source_code == 4'hF;
   endproperty
   property p_std;
      !HB_DRIVE[1].low_current_enable |->
         HB_DRIVE[1].source_ua == gdc_pkg::STD_UA[HB_DRIVE[1].source_code];
   endproperty
   property p_low;
      HB_DRIVE[2].low_current_enable |->
         HB_DRIVE[2].sink_ua == gdc_pkg::LOW_UA[HB_DRIVE[2].sink_code];
   endproperty
   property p_rd_answer;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0;
   endproperty
   property p_rd_block;
      S_AXI_RVALID |-> !S_AXI_ARREADY;
   endproperty
   property p_ce_freeze;
      !CE |-> !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_ARREADY;
   endproperty
   a_wr_hb1: assert property (p_wr_hb1) else $error("hb1 drive codes differ from write");
   a_wr_resp: assert property (p_wr_resp) else $error("hb1 write not answered okay");
   a_reset_val: assert property (p_reset_val) else $error("drive codes not all ones");
   a_std: assert property (p_std) else $error("standard current decode wrong");
   a_low: assert property (p_low) else $error("low current decode wrong");
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
   a_rd_block: assert property (p_rd_block) else $error("read accepted while busy");
   a_ce_freeze: assert property (p_ce_freeze) else $error("ready high while disabled");
endmodule
bind gate_drive_current_cfg_regs gate_drive_current_cfg_regs_asserts u_chk (.CLK, .ARST_N,
   .CE, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .HB_DRIVE);

// file: gate_drive_current_cfg_regs_bench.sv
// Self-checking bench for the gate-drive current register bank.
`timescale 1ns/1ns
module gate_drive_current_cfg_regs_bench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   gdc_pkg::hb_drive_s [2:0] hb;
   int n_errors = 0;
   int comparisons = 0;
   int std_ua [16] = '{500, 1000, 2000, 3000, 4000, 5000, 6000, 7000, 8000, 12000, 16000,
                       20000, 24000, 31000, 48000, 62000};
   int low_ua [16] = '{50, 110, 170, 230, 290, 350, 410, 600, 725, 850, 1000, 1200, 1400,
                       1600, 1800, 2300};
   always #50 clk = ~clk;
   // Response readies stay high: legal, and it keeps every answer on its first edge.
   gate_drive_current_cfg_regs u_dut (.CLK(clk), .ARST_N(arst_n), .CE(ce),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
      .HB_DRIVE(hb));
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Bus cycles, entered just after a rising edge
   // ---------------------------------------------------------------
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic s,
                     input logic [1:0] er);
      logic ta, tw, b;
      logic [1:0] r;
      int n;
      b = 1'b0;
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= {3'h0, s};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b && n < 50) begin
         @(negedge clk);
         ta = awready;
         tw = wready;
         b = bvalid;
         r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         n++;
      end
      check("bvalid", b, 1'b1);
      check("bresp", r, er);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
      logic ta, v;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      v = 1'b0;
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      while (!v && n < 50) begin
         @(negedge clk);
         ta = arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         n++;
      end
      check("rvalid", v, 1'b1);
      check("rdata", d, ed);
      check("rresp", r, er);
   endtask
   task automatic hb_chk(input int i, input logic [7:0] c, input logic lo);
      @(negedge clk);
      check("codes", {hb[i].source_code, hb[i].sink_code}, c);
      check("low", hb[i].low_current_enable, lo);
      check("src ua", hb[i].source_ua, lo ? low_ua[c[7:4]] : std_ua[c[7:4]]);
      check("snk ua", hb[i].sink_ua, lo ? low_ua[c[3:0]] : std_ua[c[3:0]]);
      @(posedge clk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         rd(6'(gdc_pkg::IDX_HB1 + i), 32'hFF, gdc_pkg::RESP_OKAY);
         hb_chk(i, 8'hFF, 1'b0);
      end
      rd(gdc_pkg::IDX_LOW, 32'h00, gdc_pkg::RESP_OKAY);
   endtask
   task automatic t_codes;
      logic [7:0] v;
      for (int m = 0; m < 2; m++) begin
         wr(gdc_pkg::IDX_LOW, m ? 8'hE0 : 8'h00, 1'b1, gdc_pkg::RESP_OKAY);
         for (int c = 0; c < 16; c++) begin
            v = {c[3:0], ~c[3:0]};
            wr(6'(gdc_pkg::IDX_HB1 + c % 3), v, 1'b1, gdc_pkg::RESP_OKAY);
            hb_chk(c % 3, v, m[0]);
            rd(6'(gdc_pkg::IDX_HB1 + c % 3), {24'h0, v}, gdc_pkg::RESP_OKAY);
         end
      end
   endtask
   task automatic t_err;
      wr(6'h00, 8'h5A, 1'b1, gdc_pkg::RESP_SLVERR);
      rd(6'h00, 32'h0, gdc_pkg::RESP_SLVERR);
      wr(gdc_pkg::IDX_HB2, 8'h12, 1'b1, gdc_pkg::RESP_OKAY);
      wr(gdc_pkg::IDX_HB2, 8'h34, 1'b0, gdc_pkg::RESP_OKAY);
      rd(gdc_pkg::IDX_HB2, 32'h12, gdc_pkg::RESP_OKAY);
      hb_chk(1, 8'h12, 1'b1);
   endtask
   task automatic t_ce_rst;
      ce <= 1'b0;
      @(negedge clk);
      check("ready off", {awready, wready, arready}, 3'h0);
      @(posedge clk);
      ce <= 1'b1;
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(gdc_pkg::IDX_HB3, 32'hFF, gdc_pkg::RESP_OKAY);
      hb_chk(2, 8'hFF, 1'b0);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_codes();
      t_err();
      t_ce_rst();
      test_done();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      test_done();
   end
endmodule
